// [btv_core.sv]
// turning mode and vandalism handling of the pivot barrier motor logic
// assumes sensor inputs are synchronous; a power cycle is seen as resetn_i
//
// Functional notes
// R01 - continuous turning off: drive element home after every completed passage
// R02 - continuous turning on: no homing, back-to-back passages while impulses remain
// R03 - threshold off: vandalism error at once on wrong-direction movement
// R04 - threshold on: vandalism error only beyond 20 degrees from home
// R05 - threshold on: brake may engage before the 20 degree threshold
// R06 - buzzer only while latching or braking; may stop with error pending
// R07 - latch off: error shown until inspection or display time expiry
// R08 - latch on: error after third grating, held until power cycle
// R09 - latched vandalism keeps brake engaged and buzzer sounding until power cycle
// R10 - configuration switches synchronised and debounced before use
module btv_core #(
	parameter int DEB_CYC  = btv_pkg::DEB_CYC,
	parameter int DISP_CYC = btv_pkg::DISP_CYC
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  resetn_i,
	input  wire logic [btv_pkg::SW_W-1:0] sw_cfg_i,
	input  wire logic                  clear_imp_i,
	input  wire logic                  passage_done_i,
	input  wire logic                  inspect_i,
	input  wire btv_pkg::btv_sense_type sense_i,
	output logic                       drive_home_o,
	output logic                       pass_enable_o,
	output logic                       brake_o,
	output logic                       buzzer_o,
	output logic                       vand_err_o,
	output logic                       vand_locked_o
);

	logic [btv_pkg::SW_W-1:0] cfg;
	btv_pkg::btv_core_type    q;
	btv_pkg::btv_core_type    d;
	logic                     cont_turn;
	logic                     vand_thresh;
	logic                     vand_latch;
	logic                     trig;
	logic                     new_attempt;
	logic                     go_lock;
	logic                     imp_dec;

	// one debouncer per switch; slow settling traded for glitch-free mode changes
	for (genvar i = 0; i < btv_pkg::SW_W; i++) begin : g_sw
		btv_debounce #(
			.CNT_MAX (DEB_CYC)
		) u_deb (
			.core_clk_i (core_clk_i),
			.resetn_i   (resetn_i),
			.raw_i      (sw_cfg_i[i]),
			.clean_o    (cfg[i])
		); // see R10
	end

	assign cont_turn   = cfg[btv_pkg::SW_CONT_POS];
	assign vand_thresh = cfg[btv_pkg::SW_THRESH_POS];
	assign vand_latch  = cfg[btv_pkg::SW_LATCH_POS];

	// angle only matters with the threshold enabled
	assign trig = sense_i.wrong_dir &&
		(!vand_thresh || sense_i.angle_deg > btv_pkg::VAND_THRESH_DEG); // see R03 see R04
	assign new_attempt = trig && !q.trig_prev;
	assign go_lock     = vand_latch && new_attempt && !q.act.locked &&
		q.attempts == btv_pkg::ATTEMPT_LOCK - 2'h1; // see R08
	assign imp_dec     = q.st == btv_pkg::ST_PASS && passage_done_i;

	always_comb begin
		d           = q;
		d.trig_prev = trig;

		// stored clearance impulses; simultaneous add and use cancel out
		if (clear_imp_i && !imp_dec && q.imp_cnt != btv_pkg::IMP_MAX) begin
			d.imp_cnt = q.imp_cnt + btv_pkg::IMP_W'(1);
		end else if (imp_dec && !clear_imp_i && q.imp_cnt != btv_pkg::IMP_RST) begin
			d.imp_cnt = q.imp_cnt - btv_pkg::IMP_W'(1);
		end

		if (new_attempt && q.attempts != btv_pkg::ATTEMPT_LOCK) begin
			d.attempts = q.attempts + 2'h1;
		end

		case (q.st)
			btv_pkg::ST_IDLE: begin
				if (q.imp_cnt != btv_pkg::IMP_RST) begin
					d.st = btv_pkg::ST_PASS;
				end
			end
			btv_pkg::ST_PASS: begin
				if (passage_done_i) begin
					if (!cont_turn) begin
						d.st = btv_pkg::ST_HOME; // see R01
					end else if (d.imp_cnt == btv_pkg::IMP_RST) begin
						d.st = btv_pkg::ST_IDLE; // see R02
					end
				end
			end
			btv_pkg::ST_HOME: begin
				if (sense_i.at_home) begin
					d.st = btv_pkg::ST_IDLE; // see R01
				end
			end
			btv_pkg::ST_LOCK: begin
				d.st = btv_pkg::ST_LOCK; // see R08
			end
			default: begin
				d.st = btv_pkg::ST_IDLE;
			end
		endcase
		if (go_lock) begin
			d.st = btv_pkg::ST_LOCK;
		end

		// error flag: a new trigger wins over any clear in the same cycle
		if (trig) begin
			d.act.vand_err = 1'b1; // see R03 see R04
			d.disp_cnt     = btv_pkg::DISP_W'(DISP_CYC - 1);
		end else if (!q.act.locked && q.act.vand_err) begin
			if (inspect_i || q.disp_cnt == btv_pkg::DISP_RST) begin
				d.act.vand_err = 1'b0; // see R07
			end else begin
				d.disp_cnt = q.disp_cnt - btv_pkg::DISP_W'(1);
			end
		end

		d.act.locked      = q.act.locked || go_lock; // see R08
		d.act.drive_home  = d.st == btv_pkg::ST_HOME;
		d.act.pass_enable = d.st == btv_pkg::ST_PASS;
		// any wrong-direction push brakes, even below the error threshold
		d.act.brake       = sense_i.wrong_dir || d.act.locked; // see R05 see R09
		// buzzer follows latching or braking only, so it may fall silent with the error held
		d.act.buzzer      = d.act.locked ||
			(d.act.vand_err && (sense_i.latch_step || d.act.brake)); // see R06 see R09
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			q.st        <= btv_pkg::ST_IDLE;
			q.imp_cnt   <= btv_pkg::IMP_RST;
			q.attempts  <= btv_pkg::ATTEMPT_RST;
			q.trig_prev <= 1'b0;
			q.disp_cnt  <= btv_pkg::DISP_RST;
			q.act       <= '0;
		end else begin
			q <= d;
		end
	end

	assign drive_home_o  = q.act.drive_home;
	assign pass_enable_o = q.act.pass_enable;
	assign brake_o       = q.act.brake;
	assign buzzer_o      = q.act.buzzer;
	assign vand_err_o    = q.act.vand_err;
	assign vand_locked_o = q.act.locked;

	property p_home_after_pass;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(q.st == btv_pkg::ST_PASS && passage_done_i && !cont_turn && !go_lock)
			|=> drive_home_o && !pass_enable_o;
	endproperty
	a_home_after_pass: assert property (p_home_after_pass) else $error("no homing after passage"); // see R01

	property p_no_home_cont;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(q.st == btv_pkg::ST_PASS && passage_done_i && cont_turn && q.imp_cnt > 4'h1
			&& !go_lock) |=> pass_enable_o && !drive_home_o;
	endproperty
	a_no_home_cont: assert property (p_no_home_cont) else $error("continuous turning broke passage"); // see R02

	property p_err_at_once;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(sense_i.wrong_dir && !vand_thresh) |=> vand_err_o;
	endproperty
	a_err_at_once: assert property (p_err_at_once) else $error("error late without threshold"); // see R03

	property p_err_threshold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(vand_thresh && sense_i.angle_deg <= btv_pkg::VAND_THRESH_DEG && !vand_err_o)
			|=> !vand_err_o;
	endproperty
	a_err_threshold: assert property (p_err_threshold) else $error("error raised below 20 degrees"); // see R04

	property p_brake_early;
		@(posedge core_clk_i) disable iff (!resetn_i)
		sense_i.wrong_dir |=> brake_o;
	endproperty
	a_brake_early: assert property (p_brake_early) else $error("brake missing on wrong push"); // see R05

	property p_buzz_cause;
		@(posedge core_clk_i) disable iff (!resetn_i)
		buzzer_o |-> vand_locked_o || (vand_err_o && (brake_o || $past(sense_i.latch_step)));
	endproperty
	a_buzz_cause: assert property (p_buzz_cause) else $error("buzzer without latching or brake"); // see R06

	property p_inspect_clears;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(vand_err_o && !vand_locked_o && inspect_i && !trig) |=> !vand_err_o;
	endproperty
	a_inspect_clears: assert property (p_inspect_clears) else $error("inspection did not clear error"); // see R07

	property p_disp_expire;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(vand_err_o && !vand_locked_o && q.disp_cnt == btv_pkg::DISP_RST && !trig)
			|=> !vand_err_o;
	endproperty
	a_disp_expire: assert property (p_disp_expire) else $error("error outlived display time"); // see R07

	property p_lock_third;
		@(posedge core_clk_i) disable iff (!resetn_i)
		go_lock |=> vand_locked_o && vand_err_o ##1 vand_locked_o && vand_err_o;
	endproperty
	a_lock_third: assert property (p_lock_third) else $error("third grating did not latch"); // see R08

	property p_lock_outputs;
		@(posedge core_clk_i) disable iff (!resetn_i)
		vand_locked_o |-> brake_o && buzzer_o && !pass_enable_o;
	endproperty
	a_lock_outputs: assert property (p_lock_outputs) else $error("latched state lost brake or buzzer"); // see R09

	// only a power cycle may leave the latched state
	property p_lock_kept;
		@(posedge core_clk_i) disable iff (!resetn_i)
		vand_locked_o |=> vand_locked_o && vand_err_o && brake_o && buzzer_o;
	endproperty
	a_lock_kept: assert property (p_lock_kept) else $error("latched state released without reset"); // see R09

endmodule

// [btv_debounce.sv]
// two-flop synchroniser followed by a stability counter for one switch
// assumes the raw switch is asynchronous and slow compared to the clock
module btv_debounce #(
	parameter int CNT_MAX = btv_pkg::DEB_CYC
) (
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	input  wire logic raw_i,
	output logic      clean_o
);

	localparam int CW = $clog2(CNT_MAX + 1);

	typedef struct packed {
		logic          s1;
		logic          s2;
		logic          clean;
		logic [CW-1:0] cnt;
	} btv_deb_type;

	btv_deb_type q;
	btv_deb_type d;

	always_comb begin
		d    = q;
		d.s1 = raw_i;
		d.s2 = q.s1;
		if (q.s2 == q.clean) begin
			d.cnt = '0;
		end else if (q.cnt == CW'(CNT_MAX - 1)) begin
			d.clean = q.s2; // see R10
			d.cnt   = '0;
		end else begin
			d.cnt = q.cnt + CW'(1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign clean_o = q.clean;

	property p_deb_stable;
		@(posedge core_clk_i) disable iff (!resetn_i)
		$changed(q.clean) |-> $past(q.cnt) == CW'(CNT_MAX - 1) && $past(q.s2) == q.clean;
	endproperty
	a_deb_stable: assert property (p_deb_stable) else $error("switch output moved before settling"); // see R10

endmodule

// [btv_far_model.sv]
// far-side model: blocking element, homing travel and angle sensing
// assumes drive_home_i is a registered level on the core clock
module btv_far_model (
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	input  wire logic             drive_home_i,
	input  wire logic             slow_i,
	input  wire logic             wrong_dir_i,
	input  wire logic [7:0]       angle_i,
	output btv_pkg::btv_sense_type sense_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int travel = 0;
	int step_cnt = 0;
	// outputs move just after the edge, like a real sensor;
	// later than the bench's own drive, so a push is never read in a race
	always @(posedge core_clk_i) begin
		#2;
		travel = (!resetn_i || !drive_home_i) ? 0 : travel + 1;
		// slow travel shows the core holds drive_home until home is reached
		sense_o.at_home = drive_home_i && (travel > (slow_i ? 6 : 1));
		step_cnt = wrong_dir_i ? step_cnt + 1 : 0;
		sense_o.latch_step = wrong_dir_i && (step_cnt % 3 == 1);
		sense_o.wrong_dir = wrong_dir_i;
		sense_o.angle_deg = angle_i;
	end
endmodule

// [btv_pkg.sv]
// shared constants and types for the barrier turn / vandalism configuration block
// assumes a single 100 MHz core clock and a synchronous active-low reset
package btv_pkg;

	localparam int CLK_HZ       = 100_000_000;
	localparam int CYC_PER_MS   = CLK_HZ / 1000;
	localparam int DEB_TIME_MS  = 10;
	localparam int DEB_CYC      = DEB_TIME_MS * CYC_PER_MS;
	localparam int DISP_TIME_MS = 10000;
	localparam int DISP_CYC     = DISP_TIME_MS * CYC_PER_MS;

	localparam int IMP_W  = 4;
	localparam int DISP_W = 30;
	localparam int SW_W   = 3;

	localparam int SW_CONT_POS   = 0;
	localparam int SW_THRESH_POS = 1;
	localparam int SW_LATCH_POS  = 2;

	localparam logic [7:0]        VAND_THRESH_DEG = 8'h14;
	localparam logic [1:0]        ATTEMPT_LOCK    = 2'h3;
	localparam logic [IMP_W-1:0]  IMP_MAX         = 4'hf;
	localparam logic [IMP_W-1:0]  IMP_RST         = 4'h0;
	localparam logic [1:0]        ATTEMPT_RST     = 2'h0;
	localparam logic [DISP_W-1:0] DISP_RST        = 30'h0;
	localparam logic [SW_W-1:0]   CFG_RST         = 3'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PASS = 2'b01,
		ST_HOME = 2'b10,
		ST_LOCK = 2'b11
	} btv_state_type;

	typedef struct packed {
		logic       wrong_dir;
		logic [7:0] angle_deg;
		logic       latch_step;
		logic       at_home;
	} btv_sense_type;

	typedef struct packed {
		logic       drive_home;
		logic       pass_enable;
		logic       brake;
		logic       buzzer;
		logic       vand_err;
		logic       locked;
	} btv_act_type;

	typedef struct packed {
		btv_state_type     st;
		logic [IMP_W-1:0]  imp_cnt;
		logic [1:0]        attempts;
		logic              trig_prev;
		logic [DISP_W-1:0] disp_cnt;
		btv_act_type       act;
	} btv_core_type;

endpackage

// [tb_barrier_turn_vandal_config.sv]
// bench for the turning and vandalism core, with the far-side model
// assumes debounce and display counts are shortened for simulation
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
	$display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb_barrier_turn_vandal_config;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEB  = 4;
	localparam int DISP = 20;
	logic                   clk = 1'b0;
	logic                   resetn = 1'b0;
	logic [2:0]             sw = 3'h0;
	logic                   clr_imp = 1'b0;
	logic                   pass_done = 1'b0;
	logic                   inspect = 1'b0;
	logic                   slow = 1'b0;
	logic                   wdir = 1'b0;
	logic [7:0]             angle = 8'h00;
	btv_pkg::btv_sense_type sense;
	logic                   home, pass_en, brake, buzz, err, locked;
	int                     n_fail = 0;
	int                     n_checks = 0;
	int                     seed = 97;
	int                     imp = 0;
	int                     n;

	always #5 clk = ~clk;

	btv_core #(.DEB_CYC(DEB), .DISP_CYC(DISP)) i_dut (
		.core_clk_i(clk), .resetn_i(resetn), .sw_cfg_i(sw), .clear_imp_i(clr_imp),
		.passage_done_i(pass_done), .inspect_i(inspect), .sense_i(sense),
		.drive_home_o(home), .pass_enable_o(pass_en), .brake_o(brake),
		.buzzer_o(buzz), .vand_err_o(err), .vand_locked_o(locked));

	btv_far_model i_far (
		.core_clk_i(clk), .resetn_i(resetn), .drive_home_i(home), .slow_i(slow),
		.wrong_dir_i(wdir), .angle_i(angle), .sense_o(sense));

	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task end_sim;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// debouncer needs DEB+2 edges; margin kept small
	task set_sw(input logic [2:0] v);
		sw = v;
		step(DEB + 4);
		`CHK("sw_cfg", v, i_dut.cfg)
	endtask

	// bounded wait: 0 = passage enabled, 1 = homing finished
	task wait_for(input int sel);
		for (int i = 0; i < 40; i++) begin
			if ((sel == 0 && pass_en === 1'b1) || (sel == 1 && home === 1'b0))
				return;
			step(1);
		end
		n_fail++;
		$display("mismatch wait %0d exp 1 got 0", sel);
		end_sim();
	endtask

	// model: one stored impulse used per passage; done held high across back-to-back calls
	task passage(input logic cont, input logic last);
		pass_done = 1'b1;
		step(1);
		if (last)
			pass_done = 1'b0;
		imp--;
		`CHK("drive_home", !cont, home)
		`CHK("pass_enable", cont && imp > 0, pass_en)
	endtask

	// push in the wrong direction, then let go
	task vand(input logic [7:0] a, input logic e, input logic lk);
		wdir = 1'b1;
		angle = a;
		step(1);
		`CHK("brake", 1'b1, brake)
		`CHK("vand_err", e, err)
		step(1);
		`CHK("buzzer", e, buzz)
		wdir = 1'b0;
		angle = 8'h00;
		step(2);
		`CHK("brake_off", lk, brake)
		`CHK("buzzer_off", lk, buzz)
		`CHK("err_held", e, err)
	endtask

	task pulse_inspect;
		inspect = 1'b1;
		step(1);
		inspect = 1'b0;
		step(1);
	endtask

	initial begin
		step(5);
		resetn = 1'b1;
		step(1);
		`CHK("outs_reset", 6'h00, {home, pass_en, brake, buzz, err, locked})
		// short glitch on the turning switch must not count
		sw = 3'h1;
		step(2);
		sw = 3'h0;
		step(DEB);
		`CHK("sw_glitch", 3'h0, i_dut.cfg)
		set_sw(3'h0);
		slow = 1'($random(seed));
		clr_imp = 1'b1;
		step(1);
		clr_imp = 1'b0;
		imp = 1;
		wait_for(0);
		passage(1'b0, 1'b1);
		wait_for(1);
		`CHK("idle_after_home", 1'b0, pass_en)
		$display("test homing done");
		set_sw(3'h1);
		n = 2 + ($unsigned($random(seed)) % 3);
		clr_imp = 1'b1;
		step(n);
		clr_imp = 1'b0;
		imp = n;
		wait_for(0);
		for (int i = 0; i < n; i++) passage(1'b1, i == n - 1);
		$display("test continuous done");
		set_sw(3'h0);
		vand(8'h05, 1'b1, 1'b0);
		pulse_inspect();
		`CHK("err_inspect", 1'b0, err)
		set_sw(3'h2);
		vand(8'($unsigned($random(seed)) % 21), 1'b0, 1'b0);
		vand(8'h15, 1'b1, 1'b0);
		step(DISP + 2);
		`CHK("err_expired", 1'b0, err)
		$display("test vandalism done");
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		set_sw(3'h4);
		repeat (2) begin
			vand(8'h05, 1'b1, 1'b0);
			pulse_inspect();
		end
		`CHK("not_locked", 1'b0, locked)
		vand(8'h05, 1'b1, 1'b1);
		pulse_inspect();
		step(DISP + 5);
		`CHK("lock_hold", 4'hf, {locked, err, brake, buzz})
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		step(1);
		`CHK("lock_cleared", 1'b0, locked)
		$display("test latch done");
		end_sim();
	end
endmodule
